// >>> hw/home_timing_cfg.svh
// Purpose: offsets, field positions and reset values of the timing source block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   byte addresses, decoded on paddr[7:0]
`ifndef HOME_TIMING_CFG_SVH
`define HOME_TIMING_CFG_SVH

`define HT_ADDR_W        8
`define HT_OFF_TIM       8'h00
`define HT_OFF_ENC       8'h04
`define HT_OFF_CTRL      8'h08
`define HT_OFF_STAT      8'h0C
`define HT_OFF_ISTAT     8'h10
`define HT_OFF_IMASK     8'h14

// factory values
`define HT_TIM_FACTORY   1'h1
`define HT_ENC_FACTORY   2'h0

// timing source select codes
`define HT_TIM_SHARED    1'h0
`define HT_TIM_SINGLE    1'h1

// bit of the timing select in its register
`define HT_TIM_BIT       0

// ctrl bits (write only, self clearing)
`define HT_CTRL_SAVE     0
`define HT_CTRL_RESET    1

// status bits
`define HT_STAT_TIM      0
`define HT_STAT_ENC_LO   4
`define HT_STAT_ENC_HI   5
`define HT_STAT_TIMING   8
`define HT_STAT_NOSRC    9

// interrupt bits
`define HT_INT_ALARM     0
`define HT_INT_EDGE      1
`define HT_INT_W         2

`endif

// >>> hw/home_timing_pkg.sv
// Purpose: types shared by the timing source block
// Assumes: nothing
// Notes:   encoder codes follow the stored parameter values
package home_timing_pkg;

	// encoder source select values
	typedef enum logic [1:0] {
		ENC_NONE,
		ENC_DRIVER,
		ENC_EXTERNAL,
		ENC_SPARE
	} enc_src_t;

	// apb answer phases
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ANSWER,
		BUS_DONE
	} bus_state_t;

endpackage

// >>> hw/home_timing_source_select.sv
// What this block does
// - select zero takes the shared path
// - select one takes single-ended input; factory one
// - new select applies only after save, reset
// - select writable immediately, read-only from sequences
// - encoder one driver, two external index
// - external index only on shared path
// - single-ended select ignores encoder source
// - both zero plus timed home seek alarms
//
// Purpose: chooses the timing signal used by mechanical home seeking
// Assumes: pins pass two flip-flops; seek and sequence inputs are pclk logic
// Notes:   the save area lives in flops that only presetn returns to factory values
//          a new select reaches the pins only through a CTRL reset
//          pins take three edges to reach timing_signal
//          encoder value 3 selects nothing and raises no alarm
//          one wait state on every APB access, then one idle cycle
`timescale 1ns/1ns
`include "home_timing_cfg.svh"
module home_timing_source_select
	import home_timing_pkg::*;
#(
	parameter int ENC_W = 2
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        seq_access,
	input  wire logic        diff_driver_timing_input,
	input  wire logic        single_ended_timing_input,
	input  wire logic        ext_encoder_index_input,
	input  wire logic        home_seek_negative,
	input  wire logic        home_seek_positive,
	input  wire logic        home_seek_type,
	output logic             timing_signal,
	output logic             system_alarm,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	// parameter check

	generate
		if (ENC_W != 2)
		begin : g_bad_width
			$error("encoder source field must be two bits wide");
		end
		if (`HT_STAT_ENC_HI - `HT_STAT_ENC_LO + 1 != ENC_W)
		begin : g_bad_status
			$error("status encoder field does not match the encoder width");
		end
		if ((`HT_INT_ALARM >= `HT_INT_W) || (`HT_INT_EDGE >= `HT_INT_W))
		begin : g_bad_int
			$error("interrupt bits must lie inside the status word");
		end
		if (`HT_ADDR_W < $clog2(`HT_OFF_IMASK + 1))
		begin : g_bad_addr
			$error("address decode too narrow for the register map");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] pins_sync;

	sync2 #(
		.WIDTH (3)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({ext_encoder_index_input,
		            single_ended_timing_input,
		            diff_driver_timing_input}),
		.sync_out (pins_sync)
	);

	logic diff_s;
	logic single_s;
	logic ext_s;

	// synchronised pin levels
	assign diff_s   = pins_sync[0];
	assign single_s = pins_sync[1];
	assign ext_s    = pins_sync[2];

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		bus_state_t             bus;
		logic [31:0]            rdata;
		logic                   err;
		logic                   tim_wr;
		logic [ENC_W-1:0]       enc_wr;
		logic                   tim_saved;
		logic [ENC_W-1:0]       enc_saved;
		logic                   tim_act;
		logic [ENC_W-1:0]       enc_act;
		logic                   timing;
		logic                   alarm;
		logic [`HT_INT_W-1:0]   istat;
		logic [`HT_INT_W-1:0]   imask;
		logic                   irq;
		logic                   ready;
	} state_t;

	state_t state_reg;
	state_t state_next;

	////////////////////////////////////////////////////////////////////////////
	// combinational helpers

	logic             diff_or_ext_index_path;
	logic             sel_timing;
	logic             no_source;
	logic             seek_start;
	logic             commit;
	logic [`HT_ADDR_W-1:0] addr8;
	logic [31:0]           rd_word;
	logic                  addr_ok;
	logic                  wr_refused;
	logic [ENC_W-1:0]      enc_field;
	logic                  wr_ok;
	logic                  wr_istat;
	logic [`HT_INT_W-1:0]  istat_set;
	logic [`HT_INT_W-1:0]  istat_clr;
	wire  [`HT_INT_W-1:0]  istat_upd;

	assign addr8     = paddr[`HT_ADDR_W-1:0];
	assign enc_field = pwdata[ENC_W-1:0];

	// shared path picks driver or external index
	always_comb
	begin
		case (enc_src_t'(state_reg.enc_act))
			ENC_DRIVER:   diff_or_ext_index_path = diff_s;
			ENC_EXTERNAL: diff_or_ext_index_path = ext_s;
			default:      diff_or_ext_index_path = 1'b0;
		endcase
	end

	// final timing source, only the active copy steers it
	always_comb
	begin
		if (state_reg.tim_act == `HT_TIM_SINGLE)
			sel_timing = single_s;
		else
			sel_timing = diff_or_ext_index_path;
	end

	// neither path configured
	assign no_source = (state_reg.tim_act == `HT_TIM_SHARED) &&
	                   (state_reg.enc_act == ENC_W'(ENC_NONE));

	// home seek launched with a timed home type
	assign seek_start = (home_seek_negative || home_seek_positive) &&
	                    home_seek_type;

	// access phase completing this cycle
	assign commit = psel && penable && (state_reg.bus == BUS_ANSWER);

	// address decode and read mux
	always_comb
	begin
		addr_ok = 1'b1;
		rd_word = 32'h0000_0000;
		case (addr8)
			`HT_OFF_TIM:
				rd_word[`HT_TIM_BIT] = state_reg.tim_wr;
			`HT_OFF_ENC:
				rd_word[ENC_W-1:0] = state_reg.enc_wr;
			`HT_OFF_CTRL:
				rd_word = 32'h0000_0000;
			`HT_OFF_STAT:
			begin
				rd_word[`HT_STAT_TIM]                   = state_reg.tim_act;
				rd_word[`HT_STAT_ENC_HI:`HT_STAT_ENC_LO] = state_reg.enc_act;
				rd_word[`HT_STAT_TIMING]                = state_reg.timing;
				rd_word[`HT_STAT_NOSRC]                 = no_source;
			end
			`HT_OFF_ISTAT:
				rd_word[`HT_INT_W-1:0] = state_reg.istat;
			`HT_OFF_IMASK:
				rd_word[`HT_INT_W-1:0] = state_reg.imask;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// sequences may read but never change the select parameters
	assign wr_refused = pwrite && seq_access &&
	                    ((addr8 == `HT_OFF_TIM) || (addr8 == `HT_OFF_ENC) ||
	                     (addr8 == `HT_OFF_CTRL));

	////////////////////////////////////////////////////////////////////////////
	// write strobes

	// writes land at the edge that samples pready high
	assign wr_ok    = commit && pwrite && addr_ok && !wr_refused;
	assign wr_istat = wr_ok && (addr8 == `HT_OFF_ISTAT);

	////////////////////////////////////////////////////////////////////////////
	// interrupt status

	// events that raise a status bit
	always_comb
	begin
		istat_set                = '0;
		istat_set[`HT_INT_ALARM] = seek_start && no_source;
		istat_set[`HT_INT_EDGE]  = sel_timing && !state_reg.timing;
	end

	// write one to clear
	assign istat_clr = wr_istat ? pwdata[`HT_INT_W-1:0] : '0;

	// per bit sticky update, an event in the clear cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < `HT_INT_W; gi = gi + 1)
		begin : g_istat
			assign istat_upd[gi] = istat_set[gi] || (state_reg.istat[gi] && !istat_clr[gi]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		state_next = state_reg;

		// apb handshake: one wait state, then pready
		case (state_reg.bus)
			BUS_IDLE:
			begin
				if (psel && penable)
				begin
					state_next.bus   = BUS_ANSWER;
					state_next.rdata = pwrite ? 32'h0000_0000 : rd_word;
					state_next.err   = !addr_ok || wr_refused;
				end
			end
			BUS_ANSWER:
			begin
				state_next.bus = BUS_DONE;
				state_next.err = 1'b0;   // error stands with pready only
			end
			BUS_DONE:
			begin
				state_next.bus = BUS_IDLE;
				state_next.err = 1'b0;
			end
			default:
				state_next.bus = BUS_IDLE;
		endcase

		// pready is a flop of its own, high for the answer cycle
		state_next.ready = (state_next.bus == BUS_ANSWER);

		// TIM and ENC writes land only in the written copies
		if (wr_ok)
		begin
			case (addr8)
				`HT_OFF_TIM:
					state_next.tim_wr = pwdata[`HT_TIM_BIT];
				`HT_OFF_ENC:
					state_next.enc_wr = enc_field;
				`HT_OFF_CTRL:
				begin
					if (pwdata[`HT_CTRL_SAVE])
					begin
						state_next.tim_saved = state_reg.tim_wr;
						state_next.enc_saved = state_reg.enc_wr;
					end
					if (pwdata[`HT_CTRL_RESET])
					begin
						// reset applies what was saved, save first if both
						state_next.tim_act = pwdata[`HT_CTRL_SAVE] ?
						                     state_reg.tim_wr : state_reg.tim_saved;
						state_next.enc_act = pwdata[`HT_CTRL_SAVE] ?
						                     state_reg.enc_wr : state_reg.enc_saved;
						state_next.tim_wr  = state_next.tim_act;
						state_next.enc_wr  = state_next.enc_act;
					end
				end
				`HT_OFF_IMASK:
					state_next.imask = pwdata[`HT_INT_W-1:0];
				default:
					state_next.imask = state_reg.imask;
			endcase
		end

		// registered timing output
		state_next.timing = sel_timing;

		// sticky status bits from the per bit update
		state_next.istat = istat_upd;

		// alarm follows its sticky status bit
		state_next.alarm = state_next.istat[`HT_INT_ALARM];

		// one level interrupt
		state_next.irq = |(state_next.istat & state_next.imask);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg           <= '0;
			state_reg.bus       <= BUS_IDLE;
			state_reg.tim_wr    <= `HT_TIM_FACTORY;
			state_reg.tim_saved <= `HT_TIM_FACTORY;
			state_reg.tim_act   <= `HT_TIM_FACTORY;
			state_reg.enc_wr    <= `HT_ENC_FACTORY;
			state_reg.enc_saved <= `HT_ENC_FACTORY;
			state_reg.enc_act   <= `HT_ENC_FACTORY;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register

	assign prdata        = state_reg.rdata;
	assign pready        = state_reg.ready;
	assign pslverr       = state_reg.err;

	// block outputs
	assign timing_signal = state_reg.timing;
	assign system_alarm  = state_reg.alarm;
	assign irq           = state_reg.irq;

endmodule

// >>> hw/sync2.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs come from outside the pclk domain
// Notes:   the first stage is read by the second only
`timescale 1ns/1ns
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	////////////////////////////////////////////////////////////////////////////
	// parameter check

	generate
		if (WIDTH < 1)
		begin : g_bad_width
			$error("synchroniser must be at least one bit wide");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// state

	// both capture stages in one state word
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// first stage takes the pin, second takes the first stage only
	always_comb
	begin
		state_next        = state_reg;
		state_next.meta   = async_in;
		state_next.stable = state_reg.meta;
	end

	// two stage capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// settled level
	assign sync_out = state_reg.stable;

endmodule

// >>> tb/home_timing_source_select_bench.sv
// Purpose: self-checking bench of the timing source block
// Assumes: one wait state on APB, pins settle within five edges
// Notes:   scenarios run in order and share the stored settings
`timescale 1ns/1ns
module home_timing_source_select_bench;
	logic        pclk, presetn, psel, penable, pwrite, seq_access;
	logic        seek_neg, seek_pos, seek_type, pready, pslverr;
	logic        timing_signal, system_alarm, irq, diff_pin, single_pin, index_pin;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [2:0]  pin_cmd;
	logic        e;
	int          fail_count, total_checks;
	// {select, encoder, pins driver/single/index, expected timing}
	localparam logic [6:0] CASES [8] = '{7'h55, 7'h52, 7'h19, 7'h12, 7'h23, 7'h24, 7'h08,
		7'h38};
	home_timing_source_select home_timing_source_select_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.seq_access(seq_access), .diff_driver_timing_input(diff_pin),
		.single_ended_timing_input(single_pin), .ext_encoder_index_input(index_pin),
		.home_seek_negative(seek_neg), .home_seek_positive(seek_pos),
		.home_seek_type(seek_type), .timing_signal(timing_signal),
		.system_alarm(system_alarm), .irq(irq));
	timing_pins_model timing_pins_model_i (.pin_cmd(pin_cmd), .diff_pin(diff_pin),
		.single_pin(single_pin), .index_pin(index_pin));
	////////////////////
	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %s got %h", $time, m, got);
		end
	endtask
	// one apb transfer, waiting on pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20)
		begin
			fail_count++;
			$display("wrong value at %0t: no pready", $time);
			finish_test();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd & m, x, "read");
		chk({31'h0, e}, 32'h0, "read error");
	endtask
	task automatic t_reset;
		chk({29'h0, timing_signal, system_alarm, irq}, 32'h0, "outputs");
		rchk(8'h00, 32'hFFFFFFFF, 32'h1);
		rchk(8'h04, 32'hFFFFFFFF, 32'h0);
		rchk(8'h0C, 32'h231, 32'h1);
		rchk(8'h14, 32'hFFFFFFFF, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_hold;
		apb(1'b1, 8'h00, 32'h0);
		rchk(8'h00, 32'hFFFFFFFF, 32'h0);
		rchk(8'h0C, 32'h1, 32'h1);
		apb(1'b1, 8'h08, 32'h1);
		rchk(8'h0C, 32'h1, 32'h1);
		apb(1'b1, 8'h08, 32'h2);
		rchk(8'h0C, 32'h231, 32'h200);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h08, 32'h2);
		rchk(8'h0C, 32'h1, 32'h0);
		rchk(8'h00, 32'hFFFFFFFF, 32'h0);
		$display("hold test done");
	endtask
	task automatic t_alarm;
		apb(1'b1, 8'h14, 32'h1);
		seek_neg <= 1'b1;
		@(posedge pclk);
		seek_neg <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({31'h0, system_alarm}, 32'h0, "untimed seek");
		seek_type <= 1'b1;
		seek_pos <= 1'b1;
		@(posedge pclk);
		seek_pos <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({30'h0, system_alarm, irq}, 32'h3, "timed seek");
		apb(1'b1, 8'h10, 32'h1);
		repeat (2) @(posedge pclk);
		chk({30'h0, system_alarm, irq}, 32'h0, "cleared");
		$display("alarm test done");
	endtask
	task automatic t_seq;
		seq_access <= 1'b1;
		apb(1'b1, 8'h04, 32'h2);
		chk({31'h0, e}, 32'h1, "sequence write");
		rchk(8'h04, 32'hFFFFFFFF, 32'h0);
		seq_access <= 1'b0;
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped");
		$display("sequence test done");
	endtask
	// eight select pair and pin cases, each pin taken or ignored
	task automatic t_route;
		logic [6:0] c;
		for (int i = 0; i < 8; i++)
		begin
			c = CASES[i];
			apb(1'b1, 8'h00, {31'h0, c[6]});
			apb(1'b1, 8'h04, {30'h0, c[5:4]});
			apb(1'b1, 8'h08, 32'h3);
			pin_cmd <= c[3:1];
			repeat (5) @(posedge pclk);
			chk({31'h0, timing_signal}, {31'h0, c[0]}, "route");
			pin_cmd <= 3'h0;
			repeat (5) @(posedge pclk);
			chk({31'h0, timing_signal}, 32'h0, "idle");
		end
		// rising timing edges set the masked edge bit, no interrupt
		rchk(8'h10, 32'h2, 32'h2);
		chk({31'h0, irq}, 32'h0, "masked edge");
		apb(1'b1, 8'h10, 32'h2);
		rchk(8'h10, 32'h2, 32'h0);
		$display("route test done");
	endtask
	////////////////////
	// 50 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// reset, scenarios, verdict
	initial
	begin
		{presetn, psel, penable, pwrite, seq_access, seek_neg, seek_pos, seek_type} = 8'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		pin_cmd = 3'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_hold();
		t_alarm();
		t_seq();
		t_route();
		finish_test();
	end
endmodule

// >>> tb/home_timing_source_select_monitor.sv
// Purpose: port checks of the timing source block
// Assumes: master holds its request until pready
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
module home_timing_source_select_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        seq_access,
	input wire logic        home_seek_negative,
	input wire logic        home_seek_positive,
	input wire logic        home_seek_type,
	input wire logic        timing_signal,
	input wire logic        system_alarm
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// write of a one to the alarm status bit
	wire logic clr_w = pready && pwrite && paddr[7:0] == 8'h10 && pwdata[0];
	////////////////////
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	answer_wait_a: assert property ($rose(penable) && psel |=> pready)
		else $error("no answer one cycle after access");
	unmapped_err_a: assert property (pready && paddr[7:0] > 8'h14 |-> pslverr)
		else $error("unmapped access not refused");
	seq_refuse_a: assert property (pready && pwrite && seq_access
		&& paddr[7:0] <= 8'h08 |-> pslverr) else $error("sequence write taken");
	read_ok_a: assert property (pready && !pwrite && paddr[7:0] <= 8'h14
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("read refused");
	nosrc_idle_a: assert property (pready && !pwrite && paddr[7:0] == 8'h0C
		&& prdata[9] |-> !prdata[8]) else $error("timing active without source");
	alarm_cause_a: assert property ($rose(system_alarm) |->
		$past(home_seek_type) && $past(home_seek_negative || home_seek_positive))
		else $error("alarm without timed seek");
	alarm_clear_a: assert property ($fell(system_alarm) |->
		$past(clr_w, 1) || $past(clr_w, 2)) else $error("alarm dropped unasked");
	cover property ($rose(system_alarm));
	cover property (pready && pslverr);
	cover property ($rose(timing_signal));
endmodule
bind home_timing_source_select home_timing_source_select_monitor
	home_timing_source_select_monitor_i (
	.pclk               (pclk),
	.presetn            (presetn),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.paddr              (paddr),
	.pwdata             (pwdata),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.seq_access         (seq_access),
	.home_seek_negative (home_seek_negative),
	.home_seek_positive (home_seek_positive),
	.home_seek_type     (home_seek_type),
	.timing_signal      (timing_signal),
	.system_alarm       (system_alarm)
);

// >>> tb/timing_pins_model.sv
// Purpose: timing outputs of the motor driver and the external encoder
// Assumes: every pin idles low between pulses
// Notes:   pin_cmd bit2 driver, bit1 single-ended, bit0 encoder index
`timescale 1ns/1ns
module timing_pins_model (
	input  wire logic [2:0] pin_cmd,
	output logic            diff_pin,
	output logic            single_pin,
	output logic            index_pin
);
	// pins move away from the pclk edge, as unrelated sources would
	assign #7 diff_pin = pin_cmd[2];
	assign #7 single_pin = pin_cmd[1];
	assign #7 index_pin = pin_cmd[0];
endmodule
